// ---- logic/uhped_top.sv ----
// What this block does
// - falling edge on power_switch_fault_in sets bus_power_error_flag at once
// - state_change_cancel clears itself after about six clocks of stop processing
// - idle request enters IDLE and drops bus_power_enable_out
// - disconnect watched only in DISABLED, OPERATIONAL or SUSPEND
// - high-speed disconnect checked only in OPERATIONAL
// - high-speed disconnect flagged after three consecutive bad microframe EOP samples
// - full/low-speed disconnect flagged after SE0 lasts beyond 2.5 us
// - remote wakeup watched only in SUSPEND with receive enable set
// - wakeup flagged once device K lasts beyond 2.5 us
// - host drives resume K only once firmware writes a RESUME request in SUSPEND
// - RESUME drives K, restores speed, returns to operation, flags completion
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
module uhped_top
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       power_switch_fault_in,
  output logic            bus_power_enable_out,
  input  wire logic [1:0] line_state,
  input  wire logic       hs_mode,
  input  wire logic       hs_eop_sample,
  input  wire logic       hs_eop_discon,
  output logic            drive_resume_k,
  output logic            restore_hs,
  output logic            irq
);
  typedef struct packed
  {
    uhped_pkg::uhped_state_t state;
    logic                    cancel;
    logic [2:0]              cancel_cnt;
    logic                    rwk_en;
    logic                    fault_d;
    logic                    hs_before;
    logic [1:0]              hs_bad;
    logic [24:0]             res_cnt;
    logic                    bus_power_error_flag;
    logic                    discon;
    logic                    rmtwk;
    logic                    rescmp;
    logic                    host_mask;
    logic [2:0]              port_mask;
    logic [7:0]              rdata;
  } uhped_top_t;

  uhped_top_t q_r;
  uhped_top_t q_nxt;
  logic       fs_discon_done;
  logic       wake_done;
  logic       fs_discon_cond;
  logic       wake_cond;
  logic       discon_window;
  logic       hs_discon_evt;
  logic       wr_low;
  logic [2:0] req;

  // disconnect window: FS/LS in three states, HS only while operational
  always_comb
  begin
    discon_window = (q_r.state == uhped_pkg::UHPED_DISABLED)
                 || (q_r.state == uhped_pkg::UHPED_OPERATIONAL)
                 || (q_r.state == uhped_pkg::UHPED_SUSPEND);
    fs_discon_cond = discon_window && !hs_mode && (line_state == uhped_pkg::LINE_SE0);
    wake_cond = (q_r.state == uhped_pkg::UHPED_SUSPEND) && q_r.rwk_en
             && (line_state == uhped_pkg::LINE_K);
    hs_discon_evt = (q_r.state == uhped_pkg::UHPED_OPERATIONAL) && hs_mode && hs_eop_sample
                 && hs_eop_discon && (q_r.hs_bad == 2'(uhped_pkg::HS_DISCON_COUNT - 1));
  end

  uhped_filter u_fs_discon
  (
    .mclk  (mclk),
    .rst_b (rst_b),
    .cond  (fs_discon_cond),
    .done  (fs_discon_done)
  );

  uhped_filter u_wake
  (
    .mclk  (mclk),
    .rst_b (rst_b),
    .cond  (wake_cond),
    .done  (wake_done)
  );

  assign wr_low = reg_wr && (reg_addr == uhped_pkg::ADDR_NEGO_LOW);
  assign req    = reg_wdata[uhped_pkg::REQ_MSB:0];

  // next state: register writes, state changes, event capture
  always_comb
  begin
    q_nxt = q_r;

    // sticky flags: write one clears, a same-cycle event still sets
    if (reg_wr && reg_addr == uhped_pkg::ADDR_HOST_STATUS && reg_wdata[uhped_pkg::BUS_POWER_ERROR_FLAG_BIT])
      q_nxt.bus_power_error_flag = 1'b0;
    if (reg_wr && reg_addr == uhped_pkg::ADDR_PORT_STATUS)
    begin
      if (reg_wdata[uhped_pkg::DISCON_BIT])
        q_nxt.discon = 1'b0;
      if (reg_wdata[uhped_pkg::RMTWK_BIT])
        q_nxt.rmtwk = 1'b0;
      if (reg_wdata[uhped_pkg::RESCMP_BIT])
        q_nxt.rescmp = 1'b0;
    end
    if (reg_wr && reg_addr == uhped_pkg::ADDR_NEGO_HIGH)
      q_nxt.rwk_en = reg_wdata[uhped_pkg::RWK_EN_BIT];
    if (reg_wr && reg_addr == uhped_pkg::ADDR_HOST_MASK)
      q_nxt.host_mask = reg_wdata[0];
    if (reg_wr && reg_addr == uhped_pkg::ADDR_PORT_MASK)
      q_nxt.port_mask = reg_wdata[2:0];

    // fault pin is active low; only the falling edge counts
    q_nxt.fault_d = power_switch_fault_in;
    if (q_r.fault_d && !power_switch_fault_in)
      q_nxt.bus_power_error_flag = 1'b1;

    // cancel self-clears after the stop latency; requests are ignored meanwhile
    if (q_r.cancel)
    begin
      if (q_r.cancel_cnt == 3'(uhped_pkg::CANCEL_CYC - 1))
      begin
        q_nxt.cancel     = 1'b0;
        q_nxt.cancel_cnt = 3'h0;
      end
      else
        q_nxt.cancel_cnt = q_r.cancel_cnt + 3'h1;
    end
    else if (wr_low && reg_wdata[uhped_pkg::CANCEL_BIT])
    begin
      q_nxt.cancel     = 1'b1;
      q_nxt.cancel_cnt = 3'h0;
      q_nxt.res_cnt    = '0;
    end
    else if (wr_low)
    begin
      unique case (req)
        uhped_pkg::REQ_IDLE:        q_nxt.state = uhped_pkg::UHPED_IDLE;
        uhped_pkg::REQ_WAIT_CONN:   q_nxt.state = uhped_pkg::UHPED_WAIT_CONNECT;
        uhped_pkg::REQ_DISABLED:    q_nxt.state = uhped_pkg::UHPED_DISABLED;
        uhped_pkg::REQ_OPERATIONAL: q_nxt.state = uhped_pkg::UHPED_OPERATIONAL;
        uhped_pkg::REQ_SUSPEND:
        begin
          q_nxt.state     = uhped_pkg::UHPED_SUSPEND;
          q_nxt.hs_before = hs_mode;
        end
        uhped_pkg::REQ_RESUME:
        begin
          if (q_r.state == uhped_pkg::UHPED_SUSPEND)
          begin
            q_nxt.state   = uhped_pkg::UHPED_RESUME;
            q_nxt.res_cnt = '0;
          end
        end
        default: ;
      endcase
    end

    // resume: hold K for its duration, then back to operation
    if (q_r.state == uhped_pkg::UHPED_RESUME && !q_r.cancel)
    begin
      if (q_r.res_cnt == 25'(uhped_pkg::RESUME_K_CYC - 1))
      begin
        q_nxt.state  = uhped_pkg::UHPED_OPERATIONAL;
        q_nxt.rescmp = 1'b1;
      end
      else
        q_nxt.res_cnt = q_r.res_cnt + 25'h0000001;
    end

    // high-speed samples: a good sample restarts the run of three
    if (q_r.state != uhped_pkg::UHPED_OPERATIONAL || !hs_mode)
      q_nxt.hs_bad = 2'h0;
    else if (hs_eop_sample)
    begin
      if (!hs_eop_discon || hs_discon_evt)
        q_nxt.hs_bad = 2'h0;
      else
        q_nxt.hs_bad = q_r.hs_bad + 2'h1;
    end

    if (hs_discon_evt || fs_discon_done)
      q_nxt.discon = 1'b1;
    if (wake_done)
      q_nxt.rmtwk = 1'b1;

    // read data stands one cycle after the strobe
    q_nxt.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        uhped_pkg::ADDR_NEGO_LOW:    q_nxt.rdata = {q_r.cancel, 7'h00};
        uhped_pkg::ADDR_NEGO_HIGH:   q_nxt.rdata = {7'h00, q_r.rwk_en};
        uhped_pkg::ADDR_HOST_STATUS: q_nxt.rdata = {7'h00, q_r.bus_power_error_flag};
        uhped_pkg::ADDR_PORT_STATUS: q_nxt.rdata = {5'h00, q_r.rescmp, q_r.rmtwk, q_r.discon};
        uhped_pkg::ADDR_HOST_MASK:   q_nxt.rdata = {7'h00, q_r.host_mask};
        uhped_pkg::ADDR_PORT_MASK:   q_nxt.rdata = {5'h00, q_r.port_mask};
        uhped_pkg::ADDR_PORT_STATE:  q_nxt.rdata = {5'h00, q_r.state};
        default:                     q_nxt.rdata = 8'h00;
      endcase
    end
  end

  // state register; reset starts in IDLE with power off
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q_r       <= '0;
      q_r.state <= uhped_pkg::UHPED_IDLE;
      q_r.fault_d <= 1'b1;
    end
    else
      q_r <= q_nxt;
  end

  // outputs
  assign reg_rdata            = q_r.rdata;
  assign bus_power_enable_out = (q_r.state != uhped_pkg::UHPED_IDLE);
  assign drive_resume_k       = (q_r.state == uhped_pkg::UHPED_RESUME);
  assign restore_hs           = q_r.hs_before;
  assign irq = (q_r.bus_power_error_flag && q_r.host_mask)
            || |({q_r.rescmp, q_r.rmtwk, q_r.discon} & q_r.port_mask);
endmodule // uhped_top

// ---- logic/uhped_pkg.sv ----
package uhped_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] ADDR_NEGO_LOW     = 4'h0;  // negotiation_control_low
  localparam logic [3:0] ADDR_NEGO_HIGH    = 4'h1;  // negotiation_control_high
  localparam logic [3:0] ADDR_HOST_STATUS  = 4'h2;  // host_event_status
  localparam logic [3:0] ADDR_PORT_STATUS  = 4'h3;  // port_event_status
  localparam logic [3:0] ADDR_HOST_MASK    = 4'h4;
  localparam logic [3:0] ADDR_PORT_MASK    = 4'h5;
  localparam logic [3:0] ADDR_PORT_STATE   = 4'h6;  // read-only state view

  // negotiation_control_low fields
  localparam int CANCEL_BIT = 7;
  localparam int REQ_MSB    = 2;
  // negotiation_control_high fields
  localparam int RWK_EN_BIT = 0;
  // host_event_status fields
  localparam int BUS_POWER_ERROR_FLAG_BIT = 0;
  // port_event_status fields
  localparam int DISCON_BIT  = 0;
  localparam int RMTWK_BIT   = 1;
  localparam int RESCMP_BIT  = 2;

  // state_change_request codes
  localparam logic [2:0] REQ_NONE        = 3'h0;
  localparam logic [2:0] REQ_IDLE        = 3'h1;
  localparam logic [2:0] REQ_WAIT_CONN   = 3'h2;
  localparam logic [2:0] REQ_DISABLED    = 3'h3;
  localparam logic [2:0] REQ_OPERATIONAL = 3'h4;
  localparam logic [2:0] REQ_SUSPEND     = 3'h5;
  localparam logic [2:0] REQ_RESUME      = 3'h6;

  // reset values
  localparam logic [7:0] NEGO_LOW_RST  = 8'h00;
  localparam logic [7:0] NEGO_HIGH_RST = 8'h00;
  localparam logic [7:0] MASK_RST      = 8'h00;

  // line states
  localparam logic [1:0] LINE_SE0 = 2'h0;
  localparam logic [1:0] LINE_J   = 2'h1;
  localparam logic [1:0] LINE_K   = 2'h2;

  // timing
  localparam int CLK_MHZ         = 100;
  localparam int CANCEL_CYC      = 6;      // stop processing latency
  localparam int FILT_NS         = 2500;   // 2.5 us line filter, strictly longer
  localparam int FILT_CYC        = (FILT_NS * CLK_MHZ + 999) / 1000 + 1;
  localparam int RESUME_K_US     = 20000;  // resume K duration, 20 ms
  localparam int RESUME_K_CYC    = RESUME_K_US * CLK_MHZ;
  localparam int HS_DISCON_COUNT = 3;

  typedef enum logic [2:0] {
    UHPED_IDLE,
    UHPED_WAIT_CONNECT,
    UHPED_DISABLED,
    UHPED_OPERATIONAL,
    UHPED_SUSPEND,
    UHPED_RESUME
  } uhped_state_t;

endpackage

// ---- logic/uhped_filter.sv ----
// counts how long a condition has held; done pulses once it held FILT_CYC cycles
module uhped_filter
(
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic cond,
  output logic      done
);
  typedef struct packed
  {
    logic [11:0] cnt;
    logic        fired;
  } uhped_flt_t;

  uhped_flt_t q_r;
  uhped_flt_t q_nxt;

  // fire once per continuous run so a long K does not re-raise the flag
  always_comb
  begin
    q_nxt = q_r;
    done  = 1'b0;
    if (!cond)
    begin
      q_nxt.cnt   = 12'h000;
      q_nxt.fired = 1'b0;
    end
    else if (!q_r.fired)
    begin
      if (q_r.cnt == 12'(uhped_pkg::FILT_CYC - 1))
      begin
        done        = 1'b1;
        q_nxt.fired = 1'b1;
      end
      else
        q_nxt.cnt = q_r.cnt + 12'h001;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end
endmodule // uhped_filter

// ---- dv/uhped_asserts.sv ----
// watches the register port and the event outputs of the top module
module uhped_asserts
(
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       power_switch_fault_in,
  input wire logic       bus_power_enable_out,
  input wire logic       drive_resume_k,
  input wire logic       irq
);
  logic [2:0] cnt_r;
  logic       hm_r;
  logic [2:0] pm_r;
  wire logic  mz = !hm_r && (pm_r == 3'h0);

  // shadow of the cancel window and the masks, as firmware wrote them
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r <= 3'h0;
      hm_r  <= 1'b0;
      pm_r  <= 3'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == uhped_pkg::ADDR_NEGO_LOW && reg_wdata[7]) cnt_r <= 3'h6;
      else if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
      if (reg_wr && reg_addr == uhped_pkg::ADDR_HOST_MASK) hm_r <= reg_wdata[0];
      if (reg_wr && reg_addr == uhped_pkg::ADDR_PORT_MASK) pm_r <= reg_wdata[2:0];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // idle request is only honoured once the cancel window has closed
  sequence s_ctl_read;
    reg_rd && reg_addr == uhped_pkg::ADDR_NEGO_LOW;
  endsequence
  sequence s_idle_req;
    reg_wr && reg_addr == uhped_pkg::ADDR_NEGO_LOW && reg_wdata == 8'h01 && cnt_r == 3'h0;
  endsequence

  AST_CANCEL_HELD: assert property (s_ctl_read and cnt_r != 3'h0 |=> reg_rdata[7])
    else $error("cancel bit dropped too early");
  AST_CANCEL_DONE: assert property (s_ctl_read and cnt_r == 3'h0 |=> !reg_rdata[7])
    else $error("cancel bit still set");
  AST_IDLE_POWER: assert property (s_idle_req |=> ##[0:1] !bus_power_enable_out)
    else $error("bus power kept on after idle request");
  AST_FAULT_FLAG: assert property (hm_r && $fell(power_switch_fault_in) |-> ##[1:2] irq)
    else $error("fault edge did not raise the interrupt");
  AST_MASKED_QUIET: assert property (mz && $past(mz) |-> !irq)
    else $error("interrupt with all masks clear");
  AST_FLAG_STICKY: assert property (irq && !reg_wr && !$past(reg_wr) |=> irq)
    else $error("interrupt fell without a write");
  AST_RESUME_CAUSE: assert property ($rose(drive_resume_k) |->
    $past(reg_wr && reg_addr == uhped_pkg::ADDR_NEGO_LOW && reg_wdata[2:0] == uhped_pkg::REQ_RESUME))
    else $error("resume K started without a request");
  AST_RDATA_REST: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside the read cycle");
  AST_UNMAPPED: assert property (reg_rd && reg_addr > uhped_pkg::ADDR_PORT_STATE |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");
endmodule // uhped_asserts

bind uhped_top uhped_asserts u_chk (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .power_switch_fault_in, .bus_power_enable_out, .drive_resume_k, .irq);

// ---- dv/uhped_dev_model.sv ----
// attached device and power switch; a released line is pulled to SE0
module uhped_dev_model
(
  input  wire logic       mclk,
  output logic            power_switch_fault_in,
  output logic      [1:0] line_state,
  output logic            hs_mode,
  output logic            hs_eop_sample,
  output logic            hs_eop_discon
);
  timeunit 1ns;
  timeprecision 1ps;

  // switch healthy, no device attached
  initial
  begin
    power_switch_fault_in = 1'b1;
    line_state            = 2'h0;
    hs_mode               = 1'b0;
    hs_eop_sample         = 1'b0;
    hs_eop_discon         = 1'b0;
  end

  task automatic line(input logic [1:0] v);
    @(posedge mclk) line_state <= v;
  endtask

  task automatic speed(input logic v);
    @(posedge mclk) hs_mode <= v;
  endtask

  // fault pin pulses low once, then the switch recovers
  task automatic fault();
    @(posedge mclk) power_switch_fault_in <= 1'b0;
    @(posedge mclk) power_switch_fault_in <= 1'b1;
  endtask

  // discon level is only meaningful beside the sample, so scramble it after
  task automatic hs_smp(input logic d);
    @(posedge mclk);
    hs_eop_sample <= 1'b1;
    hs_eop_discon <= d;
    @(posedge mclk);
    hs_eop_sample <= 1'b0;
    hs_eop_discon <= ~d;
  endtask
endmodule // uhped_dev_model

// ---- dv/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk;
  logic       rst_b;
  logic       reg_wr;
  logic       reg_rd;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata, rv;
  logic       pwr, fault, hs_mode, smp, dis, res_k, rest_hs, irq;
  logic [1:0] line_st;
  int         error_cnt = 0;
  int         n_tests   = 0;
  int         k;

  // bus idle and reset asserted from time zero
  initial
  begin
    mclk      = 1'b0;
    rst_b     = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
  end

  // 100 MHz clock
  always #5 mclk = ~mclk;

  uhped_top u_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_switch_fault_in(fault), .bus_power_enable_out(pwr),
    .line_state(line_st), .hs_mode(hs_mode), .hs_eop_sample(smp), .hs_eop_discon(dis),
    .drive_resume_k(res_k), .restore_hs(rest_hs), .irq(irq));
  uhped_dev_model u_dev (.mclk(mclk), .power_switch_fault_in(fault), .line_state(line_st), .hs_mode(hs_mode),
    .hs_eop_sample(smp), .hs_eop_discon(dis));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // data stands only in the cycle after the read edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // firmware abort: cancel, poll until clear, then go idle
  task automatic abort_idle();
    wr(4'h0, 8'h80);
    rd(4'h0, rv);
    chk(rv, 8'h80);
    for (k = 0; k < 8 && rv[7]; k++) rd(4'h0, rv);
    chk(rv, 8'h00);
    wr(4'h0, 8'h01);
    repeat (2) @(posedge mclk);
    chk({6'h00, res_k, pwr}, 8'h00);
    rchk(4'h6, 8'h00);
  endtask

  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // hang guard, far beyond the roughly 1250 cycles the run needs
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    conclude();
  end

  initial
  begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    rchk(4'h0, 8'h00);
    chk({7'h00, pwr}, 8'h00);
    wr(4'hF, 8'hFF);
    rchk(4'hF, 8'h00);
    wr(4'h0, 8'h02);
    wr(4'h4, 8'h01);
    repeat (2) @(posedge mclk);
    chk({7'h00, pwr}, 8'h01);
    u_dev.fault();
    repeat (3) @(posedge mclk);
    chk({7'h00, irq}, 8'h01);
    rchk(4'h2, 8'h01);
    abort_idle();
    wr(4'h2, 8'h01);
    rchk(4'h2, 8'h00);
    // high speed: a good sample restarts the run of three
    u_dev.line(2'h1);
    wr(4'h0, 8'h04);
    u_dev.speed(1'b1);
    for (int i = 0; i < 5; i++) u_dev.hs_smp(i != 2);
    rchk(4'h3, 8'h00);
    u_dev.hs_smp(1'b1);
    rchk(4'h3, 8'h01);
    // full speed: SE0 must outlast the filter
    u_dev.speed(1'b0);
    wr(4'h3, 8'h01);
    u_dev.line(2'h0);
    repeat (240) @(posedge mclk);
    rchk(4'h3, 8'h00);
    repeat (20) @(posedge mclk);
    rchk(4'h3, 8'h01);
    wr(4'h0, 8'h02);
    wr(4'h3, 8'h01);
    repeat (300) @(posedge mclk);
    rchk(4'h3, 8'h00);
    // wakeup only counts in suspend with receive enabled
    u_dev.line(2'h1);
    wr(4'h0, 8'h04);
    u_dev.speed(1'b1);
    wr(4'h0, 8'h05);
    repeat (2) @(posedge mclk);
    chk({7'h00, rest_hs}, 8'h01);
    u_dev.line(2'h2);
    repeat (300) @(posedge mclk);
    rchk(4'h3, 8'h00);
    u_dev.line(2'h1);
    wr(4'h1, 8'h01);
    wr(4'h5, 8'h02);
    u_dev.line(2'h2);
    repeat (240) @(posedge mclk);
    rchk(4'h3, 8'h00);
    repeat (20) @(posedge mclk);
    rchk(4'h3, 8'h02);
    chk({7'h00, irq}, 8'h01);
    wr(4'h0, 8'h06);
    repeat (2) @(posedge mclk);
    chk({7'h00, res_k}, 8'h01);
    abort_idle();
    conclude();
  end
endmodule // testbench
